// ### bench/spfb_remote.sv
// Remote serial partner: sends frames on the receive line, captures transmitted ones
`default_nettype none
module spfb_remote (
   // Clock
   input wire logic clock,
   // Serial lines
   input wire logic txd,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rxd = 1'b1;
   // ==========================================
   // Start bit, then n bits LSB first; the caller supplies ninth and stop bits
   task automatic send(input logic [9:0] bits, input int n, input int len);
      for (int i = 0; i <= n; i++) begin
         rxd <= (i == 0) ? 1'b0 : bits[i-1];
         repeat (len) @(posedge clock);
      end
      rxd <= 1'b1;
   endtask
   // Wait for a start edge, then sample each bit at its middle
   task automatic take(input int n, input int len, output logic [9:0] bits);
      bits = '0;
      @(negedge txd);
      repeat (len / 2) @(posedge clock);
      for (int i = 0; i < n; i++) begin
         repeat (len) @(posedge clock);
         bits[i] = txd;
      end
   endtask
endmodule
`default_nettype wire

// ### bench/spfb_top_asserts.sv
// Concurrent checks on the ports of the serial port block
`default_nettype none
module spfb_top_asserts (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   // Serial pins and interrupt
   input wire spfb_pkg::spfb_pins_t pins,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // ==========================================
   // Register bus handshakes
   sequence s_wtake;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_bwait;
      bvalid && !bready;
   endsequence
   property p_wans;
      s_wtake |-> ##2 bvalid;
   endproperty
   a_wans: assert property (p_wans) else $error("write answer late");
   property p_bhold;
      s_bwait |=> bvalid && $stable(bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rans;
      arvalid && arready |=> rvalid;
   endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_rhold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data moved");
   property p_wrefuse;
      bvalid |-> !awready && !wready;
   endproperty
   a_wrefuse: assert property (p_wrefuse) else $error("write taken early");
   property p_rrefuse;
      rvalid |-> !arready;
   endproperty
   a_rrefuse: assert property (p_rrefuse) else $error("read taken early");
   // ==========================================
   // Flags and transmit start
   property p_irqfall;
      $fell(irq) |-> $rose(bvalid);
   endproperty
   a_irqfall: assert property (p_irqfall) else $error("event cleared alone");
   property p_oe;
      $rose(pins.rxd_oe) |-> $rose(bvalid);
   endproperty
   a_oe: assert property (p_oe) else $error("shift out without write");
endmodule
`default_nettype wire

// ### bench/spfb_top_tb.sv
// Self-checking bench for the serial port flags and buffer block
`default_nettype none
module spfb_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [9:0] idx;
      logic [31:0] wd;
      logic [31:0] rd;
      logic [1:0] rsp;
   } spfb_row_t;
   logic clock, rstn, awvalid, wvalid, bready, arvalid, rready, rxd_in;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [9:0] f;
   spfb_pkg::spfb_pins_t pins;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   logic [7:0] shifted = 8'h00;
   spfb_row_t rows [6] = '{
      '{spfb_pkg::IDX_CTRL, 32'h0E, 32'h0E, spfb_pkg::RESP_OKAY},
      '{spfb_pkg::IDX_CTRL, 32'h00, 32'h00, spfb_pkg::RESP_OKAY},
      '{spfb_pkg::IDX_IRQ_CLR, 32'h03, 32'h00, spfb_pkg::RESP_OKAY},
      '{spfb_pkg::IDX_IRQ_EN, 32'h03, 32'h03, spfb_pkg::RESP_OKAY},
      '{spfb_pkg::IDX_BAUD, 32'h04, 32'h04, spfb_pkg::RESP_OKAY},
      '{10'h3FF, 32'h05, 32'h00, spfb_pkg::RESP_DECERR}};
   spfb_top DUT (.clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .rxd_in(rxd_in), .pins(pins), .irq(irq));
   spfb_remote remote (.clock(clock), .txd(pins.txd), .rxd(rxd_in));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         num_errors++;
         results();
      end
   end
   // ==========================================
   // Bus tasks, comparison and verdict
   task automatic wr(input logic [9:0] idx, input logic [31:0] v, input int lag = 0);
      awaddr <= {idx, 2'h0};
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (lag == 0);
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && lag > 0) begin
            lag--;
            bready <= (lag == 0);
         end
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [9:0] idx, input int lag = 0);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= (lag == 0);
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         if (rvalid && lag > 0) begin
            lag--;
            rready <= (lag == 0);
         end
      end while (!(rvalid && rready));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Receive a frame and compare control and buffer afterwards
   task automatic rxf(input logic [31:0] c, input logic [9:0] b, input int n,
      input logic [31:0] ec, input logic [31:0] ed);
      wr(spfb_pkg::IDX_CTRL, c);
      remote.send(b, n, 4);
      rd(spfb_pkg::IDX_CTRL);
      chk(d, ec);
      rd(spfb_pkg::IDX_DATA);
      chk(d, ed);
   endtask
   // Transmit one byte and capture the frame
   task automatic tx(input logic [31:0] c, input int n, input int len, input logic [31:0] v);
      wr(spfb_pkg::IDX_CTRL, c);
      fork
         remote.take(n, len, f);
         wr(spfb_pkg::IDX_DATA, v);
      join
      repeat (len) @(posedge clock);
      rd(spfb_pkg::IDX_CTRL);
      chk(d, c | 32'h02);
   endtask
   // Mode 0 shift data, taken on each rising shift clock
   always @(posedge pins.txd) begin
      if (pins.rxd_oe) shifted <= {pins.rxd_out, shifted[7:1]};
   end
   // ==========================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr} = 24'h000000;
      wdata = 32'h0;
      wstrb = 4'h0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      rd(spfb_pkg::IDX_CTRL);
      chk(d, 32'h00);
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         chk({30'h0, r}, {30'h0, rows[i].rsp});
         rd(rows[i].idx);
         chk(d, rows[i].rd);
         chk({30'h0, r}, {30'h0, rows[i].rsp});
      end
      chk({31'h0, irq}, 32'h0);
      wr(spfb_pkg::IDX_IRQ_EN, 32'h03, 2);
      rd(spfb_pkg::IDX_IRQ_EN, 2);
      chk(d, 32'h03);
      $display("register rows done");
      rxf(32'h70, 10'h13C, 9, 32'h75, 32'h3C);
      chk({31'h0, irq}, 32'h1);
      rxf(32'h70, 10'h0A5, 9, 32'h70, 32'h3C);
      rxf(32'hF0, 10'h281, 10, 32'hF0, 32'h3C);
      rxf(32'hF0, 10'h381, 10, 32'hF5, 32'h81);
      rxf(32'h40, 10'h199, 9, 32'h40, 32'h81);
      wr(spfb_pkg::IDX_IRQ_CLR, 32'h03);
      chk({31'h0, irq}, 32'h0);
      $display("receive tests done");
      tx(32'h50, 9, 4, 32'h55);
      chk({22'h0, f}, 32'h155);
      rd(spfb_pkg::IDX_DATA);
      chk(d, 32'h81);
      chk({31'h0, irq}, 32'h1);
      wr(spfb_pkg::IDX_IRQ_EN, 32'h00);
      chk({31'h0, irq}, 32'h0);
      wr(spfb_pkg::IDX_IRQ_EN, 32'h03);
      wr(spfb_pkg::IDX_IRQ_CLR, 32'h01);
      chk({31'h0, irq}, 32'h0);
      for (int k = 0; k < 2; k++) begin
         tx(k ? 32'hC0 : 32'h88, 10, k ? 4 : 64, 32'hA3);
         chk({22'h0, f}, k ? 32'h2A3 : 32'h3A3);
      end
      wr(spfb_pkg::IDX_BAUD, 32'h0001_0004);
      tx(32'h80, 10, 32, 32'h3C);
      chk({22'h0, f}, 32'h23C);
      wr(spfb_pkg::IDX_CTRL, 32'h00);
      wr(spfb_pkg::IDX_DATA, 32'h5A);
      repeat (24) @(posedge clock);
      rd(spfb_pkg::IDX_CTRL);
      chk(d, 32'h02);
      chk({24'h0, shifted}, 32'h5A);
      $display("transmit tests done");
      wr(spfb_pkg::IDX_CTRL, 32'h10);
      repeat (20) @(posedge clock);
      rd(spfb_pkg::IDX_CTRL);
      chk(d, 32'h11);
      rd(spfb_pkg::IDX_DATA);
      chk(d, 32'hFF);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      rd(spfb_pkg::IDX_CTRL);
      chk(d, 32'h00);
      $display("reset tests done");
      results();
   end
endmodule
bind spfb_top spfb_top_asserts u_asserts (.clock(clock), .rstn(rstn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
   .rready(rready), .pins(pins), .irq(irq));
`default_nettype wire

// ### hw/spfb_top.sv
// Serial port flags, ninth bit and data buffer with an AXI4-Lite register slave
`default_nettype none

module spfb_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // AXI4-Lite write channels
   input wire logic [spfb_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [spfb_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Serial pins
   input wire logic rxd_in,
   output spfb_pkg::spfb_pins_t pins,
   // Interrupt
   output logic irq
);

   // ==========================================================
   // Helpers
   function automatic logic [15:0] bit_len(input logic [1:0] mode, input logic dbl,
                                           input logic [15:0] div);
      logic [15:0] len;
      len = (div == 16'h0000) ? 16'h0001 : div;
      unique case (mode)
         spfb_pkg::MODE_SHIFT: len = spfb_pkg::LEN_SHIFT;
         spfb_pkg::MODE_UART9F: len = dbl ? spfb_pkg::LEN_FIX_DBL : spfb_pkg::LEN_FIX;
         spfb_pkg::MODE_UART8, spfb_pkg::MODE_UART9V: len = len;
      endcase
      return len;
   endfunction

   function automatic logic [3:0] last_bit(input logic [1:0] mode);
      logic [3:0] last;
      last = spfb_pkg::LAST_UART9;
      if (mode == spfb_pkg::MODE_SHIFT) begin
         last = spfb_pkg::LAST_SHIFT;
      end else if (mode == spfb_pkg::MODE_UART8) begin
         last = spfb_pkg::LAST_UART8;
      end
      return last;
   endfunction

   function automatic logic is_mapped(input logic [spfb_pkg::IDX_W-1:0] idx);
      return idx >= spfb_pkg::IDX_CTRL && idx <= spfb_pkg::IDX_BAUD;
   endfunction

   // ==========================================================
   // State
   spfb_pkg::spfb_state_t s;
   spfb_pkg::spfb_state_t next_s;
   logic [1:0] mode;
   logic [15:0] len;
   logic wr_fire;
   logic [spfb_pkg::IDX_W-1:0] ridx;
   logic tx_evt;
   logic rx_evt;
   logic rx_ok;
   logic [7:0] wbyte;

   assign mode = s.ctrl[spfb_pkg::CTL_MODE_HI:spfb_pkg::CTL_MODE_LO];
   assign len = bit_len(mode, s.dbl, s.div);
   assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
   assign ridx = araddr[spfb_pkg::ADDR_W-1:2];
   assign wbyte = s.wdata[7:0];

   assign awready = !s.aw_got && !s.bvalid;
   assign wready = !s.w_got && !s.bvalid;
   assign arready = !s.rvalid;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = s.rdata;
   assign pins = s.pins;
   assign irq = |(s.irq_st & s.irq_en);

   always_comb begin
      next_s = s;
      tx_evt = 1'b0;
      rx_evt = 1'b0;
      rx_ok = 1'b0;

      // ==========================================================
      // Write channels and register writes
      if (awvalid && awready) begin
         next_s.aw_got = 1'b1;
         next_s.awidx = awaddr[spfb_pkg::ADDR_W-1:2];
      end
      if (wvalid && wready) begin
         next_s.w_got = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = is_mapped(s.awidx) ? spfb_pkg::RESP_OKAY : spfb_pkg::RESP_DECERR;
         if (s.wstrb[0]) begin
            unique case (s.awidx)
               spfb_pkg::IDX_CTRL: next_s.ctrl = wbyte;
               spfb_pkg::IDX_IRQ_CLR: next_s.irq_st = s.irq_st & ~wbyte[1:0];
               spfb_pkg::IDX_IRQ_EN: next_s.irq_en = wbyte[1:0];
               spfb_pkg::IDX_BAUD: next_s.div[7:0] = wbyte;
               default: next_s.irq_en = next_s.irq_en;
            endcase
         end
         if (s.awidx == spfb_pkg::IDX_BAUD) begin
            if (s.wstrb[1]) begin
               next_s.div[15:8] = s.wdata[15:8];
            end
            if (s.wstrb[2]) begin
               next_s.dbl = s.wdata[spfb_pkg::BAUD_DBL];
            end
         end
      end

      // ==========================================================
      // Read channels
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = is_mapped(ridx) ? spfb_pkg::RESP_OKAY : spfb_pkg::RESP_DECERR;
         next_s.rdata = 32'h0000_0000;
         unique case (ridx)
            spfb_pkg::IDX_CTRL: next_s.rdata[7:0] = s.ctrl;
            spfb_pkg::IDX_DATA: next_s.rdata[7:0] = s.rxbuf;
            spfb_pkg::IDX_IRQ_STAT: next_s.rdata[1:0] = s.irq_st;
            spfb_pkg::IDX_IRQ_EN: next_s.rdata[1:0] = s.irq_en;
            spfb_pkg::IDX_BAUD: next_s.rdata[spfb_pkg::BAUD_DBL:0] = {s.dbl, s.div};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end

      // ==========================================================
      // Transmitter
      unique case (s.tx_st)
         spfb_pkg::TX_IDLE: begin
            if (wr_fire && s.awidx == spfb_pkg::IDX_DATA && s.wstrb[0] &&
                !(mode == spfb_pkg::MODE_SHIFT && s.rx_st == spfb_pkg::RX_BUSY)) begin
               next_s.tx_st = spfb_pkg::TX_BUSY;
               next_s.tx_cnt = len - 16'h0001;
               next_s.tx_bit = 4'h0;
               unique case (mode)
                  spfb_pkg::MODE_SHIFT: next_s.tx_sh = {3'h7, wbyte};
                  spfb_pkg::MODE_UART8: next_s.tx_sh = {2'h3, wbyte, 1'b0};
                  spfb_pkg::MODE_UART9F, spfb_pkg::MODE_UART9V:
                     next_s.tx_sh = {1'b1, s.ctrl[spfb_pkg::CTL_TB9], wbyte, 1'b0};
               endcase
            end
         end
         spfb_pkg::TX_BUSY: begin
            if (s.tx_cnt != 16'h0000) begin
               next_s.tx_cnt = s.tx_cnt - 16'h0001;
            end else if (s.tx_bit == last_bit(mode)) begin
               next_s.tx_st = spfb_pkg::TX_IDLE;
               tx_evt = (mode == spfb_pkg::MODE_SHIFT);
            end else begin
               next_s.tx_bit = s.tx_bit + 4'h1;
               next_s.tx_cnt = len - 16'h0001;
               next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
               tx_evt = (mode != spfb_pkg::MODE_SHIFT) &&
                        (s.tx_bit + 4'h1 == last_bit(mode));
            end
         end
      endcase

      // ==========================================================
      // Receiver
      next_s.rx_prev = rxd_in;
      unique case (s.rx_st)
         spfb_pkg::RX_IDLE: begin
            if (s.ctrl[spfb_pkg::CTL_REN]) begin
               if (mode == spfb_pkg::MODE_SHIFT) begin
                  if (!s.ctrl[spfb_pkg::CTL_RXF] && s.tx_st == spfb_pkg::TX_IDLE) begin
                     next_s.rx_st = spfb_pkg::RX_BUSY;
                     next_s.rx_cnt = len - 16'h0001;
                     next_s.rx_bit = 4'h0;
                  end
               end else if (s.rx_prev && !rxd_in) begin
                  next_s.rx_st = spfb_pkg::RX_BUSY;
                  next_s.rx_cnt = (len - 16'h0001) >> 1;
                  next_s.rx_bit = 4'h0;
               end
            end
         end
         spfb_pkg::RX_BUSY: begin
            if (!s.ctrl[spfb_pkg::CTL_REN]) begin
               next_s.rx_st = spfb_pkg::RX_IDLE;
            end else if (s.rx_cnt != 16'h0000) begin
               next_s.rx_cnt = s.rx_cnt - 16'h0001;
            end else if (mode == spfb_pkg::MODE_SHIFT) begin
               next_s.rx_sh = {rxd_in, s.rx_sh[7:1]};
               next_s.rx_bit = s.rx_bit + 4'h1;
               next_s.rx_cnt = len - 16'h0001;
               if (s.rx_bit == spfb_pkg::LAST_SHIFT) begin
                  next_s.rx_st = spfb_pkg::RX_IDLE;
                  next_s.rxbuf = next_s.rx_sh;
                  rx_evt = 1'b1;
               end
            end else if (s.rx_bit == 4'h0 && rxd_in) begin
               next_s.rx_st = spfb_pkg::RX_IDLE;
            end else if (s.rx_bit == last_bit(mode)) begin
               next_s.rx_st = spfb_pkg::RX_IDLE;
               if (mode == spfb_pkg::MODE_UART8) begin
                  rx_ok = !s.ctrl[spfb_pkg::CTL_AFE] || rxd_in;
                  next_s.rx_nin = rxd_in;
               end else begin
                  rx_ok = !s.ctrl[spfb_pkg::CTL_AFE] || s.rx_nin;
               end
               if (rx_ok) begin
                  next_s.rxbuf = s.rx_sh;
                  rx_evt = 1'b1;
               end
            end else begin
               if (s.rx_bit == spfb_pkg::IDX_NINTH) begin
                  next_s.rx_nin = rxd_in;
               end else if (s.rx_bit != 4'h0 && s.rx_bit <= spfb_pkg::IDX_DATA_LAST) begin
                  next_s.rx_sh = {rxd_in, s.rx_sh[7:1]};
               end
               next_s.rx_bit = s.rx_bit + 4'h1;
               next_s.rx_cnt = len - 16'h0001;
            end
         end
      endcase

      // ==========================================================
      // Hardware flag updates win over the software write
      if (tx_evt) begin
         next_s.ctrl[spfb_pkg::CTL_TXF] = 1'b1;
      end
      if (rx_evt) begin
         next_s.ctrl[spfb_pkg::CTL_RXF] = 1'b1;
         if (mode != spfb_pkg::MODE_SHIFT) begin
            next_s.ctrl[spfb_pkg::CTL_RB9] = next_s.rx_nin;
         end
      end
      next_s.irq_st[spfb_pkg::IRQ_TX] = next_s.irq_st[spfb_pkg::IRQ_TX] | tx_evt;
      next_s.irq_st[spfb_pkg::IRQ_RX] = next_s.irq_st[spfb_pkg::IRQ_RX] | rx_evt;

      // ==========================================================
      // Registered pin drive
      next_s.pins = spfb_pkg::PINS_IDLE;
      if (mode == spfb_pkg::MODE_SHIFT) begin
         if (next_s.tx_st == spfb_pkg::TX_BUSY) begin
            next_s.pins.txd = (next_s.tx_cnt == 16'h0000);
            next_s.pins.rxd_out = next_s.tx_sh[0];
            next_s.pins.rxd_oe = 1'b1;
         end else if (next_s.rx_st == spfb_pkg::RX_BUSY) begin
            next_s.pins.txd = (next_s.rx_cnt == 16'h0000);
         end
      end else if (next_s.tx_st == spfb_pkg::TX_BUSY) begin
         next_s.pins.txd = next_s.tx_sh[0];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s <= spfb_pkg::ST_RST;
      end else begin
         s <= next_s;
      end
   end

endmodule

`default_nettype wire

// ### include/spfb_pkg.sv
// Constants, types and register map of the serial port flags and buffer block
`default_nettype none

package spfb_pkg;

   // ==========================================================
   // Bus geometry and register indices (byte address = 4 * index)
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   localparam logic [IDX_W-1:0] IDX_CTRL = 10'h098;
   localparam logic [IDX_W-1:0] IDX_DATA = 10'h099;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h09A;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 10'h09B;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN = 10'h09C;
   localparam logic [IDX_W-1:0] IDX_BAUD = 10'h09D;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ==========================================================
   // Field positions of serial_control
   localparam int CTL_MODE_HI = 7;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_AFE = 5;
   localparam int CTL_REN = 4;
   localparam int CTL_TB9 = 3;
   localparam int CTL_RB9 = 2;
   localparam int CTL_TXF = 1;
   localparam int CTL_RXF = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // Interrupt bit positions and baud register layout
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam int BAUD_DBL = 16;
   localparam logic [15:0] BAUD_DIV_RST = 16'h0364;

   // ==========================================================
   // Frame modes, bit lengths in clock cycles, last bit indices
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_UART8 = 2'h1;
   localparam logic [1:0] MODE_UART9F = 2'h2;
   localparam logic [1:0] MODE_UART9V = 2'h3;
   localparam logic [15:0] LEN_SHIFT = 16'h0002;
   localparam logic [15:0] LEN_FIX_DBL = 16'h0020;
   localparam logic [15:0] LEN_FIX = 16'h0040;
   localparam logic [3:0] LAST_SHIFT = 4'h7;
   localparam logic [3:0] LAST_UART8 = 4'h9;
   localparam logic [3:0] LAST_UART9 = 4'hA;
   localparam logic [3:0] IDX_NINTH = 4'h9;
   localparam logic [3:0] IDX_DATA_LAST = 4'h8;

   // ==========================================================
   // Types
   typedef enum logic [0:0] {TX_IDLE, TX_BUSY} spfb_tx_state_t;
   typedef enum logic [0:0] {RX_IDLE, RX_BUSY} spfb_rx_state_t;

   typedef struct packed {
      logic txd;
      logic rxd_out;
      logic rxd_oe;
   } spfb_pins_t;

   localparam spfb_pins_t PINS_IDLE = '{txd: 1'b1, rxd_out: 1'b1, rxd_oe: 1'b0};

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [IDX_W-1:0] awidx;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] ctrl;
      logic [7:0] rxbuf;
      logic [1:0] irq_st;
      logic [1:0] irq_en;
      logic [15:0] div;
      logic dbl;
      spfb_tx_state_t tx_st;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [10:0] tx_sh;
      spfb_rx_state_t rx_st;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_nin;
      logic rx_prev;
      spfb_pins_t pins;
   } spfb_state_t;

   localparam spfb_state_t ST_RST = '{
      ctrl: CTRL_RST, div: BAUD_DIV_RST, tx_st: TX_IDLE, rx_st: RX_IDLE,
      rx_prev: 1'b1, pins: PINS_IDLE, default: '0};

endpackage

`default_nettype wire
